// ---- sqt_timer.sv ----
// Square-wave interval timer with its count-length and command/status bus decode
`timescale 1ns/10ps
`include "sqt_consts.svh"

// Contract
// - Two mode bits select low-second-half, square wave, single pulse or repeated pulses.
// - Square-wave period equals the count length, reloaded at every terminal count.
// - Odd count: high first half is one count longer than low half.
// - High length byte holds two mode bits over six count bits; low byte eight.
// - Timer command in command register; code 00 leaves counting untouched.
// - Command 01 stops at once when running; when idle it only ends a terminal-count pulse.
// - Command 10 halts after the present terminal count; ignored when idle.
// - Command 11 when idle loads mode and length and starts counting.
// - Command 11 while running switches to new values at terminal count.
// - Length writes take effect only after a start command.
// - Reset stops counting without setting mode or count; start needed.
// - Counter steps by two and runs through the count twice per cycle.
// - Output waveform always spans exactly the programmed number of input pulses.
// - Low mode bit set repeats the waveform; clear gives one event.
// - Count field is 14 bits, 2H through 3FFFH, mode in bits 14-15.
// - Address low bits 100 select low length byte, 101 high byte.
// - Command bits 6-7 hold the timer command; command register at 000.
// - Status bit 6 latches at terminal count, clears on status read or reset.
module sqt_timer (
  input  wire logic             clk,        // 125 MHz system clock
  input  wire logic             rst,        // Synchronous reset, active high
  input  wire sqt_pkg::sqt_pins_t pins,     // Raw bus and timer-input pins
  output logic [7:0]            ad_out,     // Read data onto the address/data bus
  output logic                  ad_oe,      // High while the block drives the bus
  output logic                  timer_out   // Timer waveform output
);

  // Three-stage synchroniser; a change counts once stages two and three agree
  sqt_pkg::sqt_pins_t s1_q, s2_q, s3_q, flt_q;
  sqt_pkg::sqt_pins_t s1_d, s2_d, s3_d, flt_d;

  always_comb begin
    s1_d  = pins;
    s2_d  = s1_q;
    s3_d  = s2_q;
    // Per-bit filter: only bits on which stage two and three agree move
    flt_d = sqt_pkg::sqt_pins_t'((flt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q)));
  end

  always_ff @(posedge clk) begin
    // Reset to the idle pin levels, so the release makes no false strobe edge
    if (rst) begin
      s1_q  <= sqt_pkg::sqt_pins_t'(`SQT_PINS_IDLE);
      s2_q  <= sqt_pkg::sqt_pins_t'(`SQT_PINS_IDLE);
      s3_q  <= sqt_pkg::sqt_pins_t'(`SQT_PINS_IDLE);
      flt_q <= sqt_pkg::sqt_pins_t'(`SQT_PINS_IDLE);
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      flt_q <= flt_d;
    end
  end

  // Edge strobes taken from the filtered levels
  logic ale_fall, rd_rise, wr_rise, tin_fall;
  assign ale_fall = ~flt_d.ale & flt_q.ale;
  assign rd_rise  = flt_d.rd_n & ~flt_q.rd_n;
  assign wr_rise  = flt_d.wr_n & ~flt_q.wr_n;
  assign tin_fall = ~flt_d.timer_in & flt_q.timer_in;

  // Bus state: address latch, held write data, length bytes, status flag
  logic [2:0]  addr_q, addr_d;
  logic        sel_q, sel_d;
  logic [7:0]  wdat_q, wdat_d;
  logic [7:0]  len_lo_q, len_lo_d;
  logic [7:0]  len_hi_q, len_hi_d;
  logic        stat_q, stat_d;
  logic [7:0]  rdat_q, rdat_d;

  // Timer state
  sqt_pkg::sqt_state_t st_q, st_d;
  sqt_pkg::sqt_mode_t  mode_q, mode_d;
  logic [`SQT_CNT_W-1:0] len_q, len_d;    // Active count length
  logic [`SQT_CNT_W-1:0] cnt_q, cnt_d;
  logic        half_q, half_d;            // 0 first half, 1 second half
  logic        start_pend_q, start_pend_d;
  logic        halt_pend_q, halt_pend_d;
  logic        pulse_q, pulse_d;          // Low pulse in pulse modes

  // Half loads: odd lengths round the first half up and the second down
  function automatic logic [`SQT_CNT_W-1:0] half_load(input logic [`SQT_CNT_W-1:0] l,
                                                       input logic second);
    half_load = second ? (l & ~`SQT_CNT_W'(1)) : (l + `SQT_CNT_W'(l[0]));
  endfunction

  logic                  wr_cmd, term;
  sqt_pkg::sqt_cmd_t     cmd;
  logic [`SQT_CNT_W-1:0] new_len;
  sqt_pkg::sqt_mode_t    new_mode;

  // Register file, command decode and timer sequencing in one next-state block
  always_comb begin
    addr_d       = addr_q;
    sel_d        = sel_q;
    wdat_d       = flt_q.wr_n ? wdat_q : flt_q.ad;
    len_lo_d     = len_lo_q;
    len_hi_d     = len_hi_q;
    stat_d       = stat_q;
    st_d         = st_q;
    mode_d       = mode_q;
    len_d        = len_q;
    cnt_d        = cnt_q;
    half_d       = half_q;
    start_pend_d = start_pend_q;
    halt_pend_d  = halt_pend_q;
    pulse_d      = pulse_q;
    new_len      = {len_hi_q[5:0], len_lo_q};
    new_mode     = sqt_pkg::sqt_mode_t'(len_hi_q[7:`SQT_MODE_POS]);
    cmd          = sqt_pkg::sqt_cmd_t'(wdat_q[7:`SQT_CMD_POS]);
    wr_cmd       = wr_rise & sel_q & (addr_q == `SQT_ADDR_CMD);
    term         = 1'b0;

    if (ale_fall) begin
      addr_d = flt_q.ad[2:0];
      sel_d  = flt_q.chip_sel & flt_q.io_sel;
    end
    // Length bytes only stage values; they reach the counter on start
    if (wr_rise & sel_q & (addr_q == `SQT_ADDR_LEN_LO)) len_lo_d = wdat_q;
    if (wr_rise & sel_q & (addr_q == `SQT_ADDR_LEN_HI)) len_hi_d = wdat_q;
    // Status read clears the flag at the end of the read strobe
    if (rd_rise & sel_q & (addr_q == `SQT_ADDR_CMD)) stat_d = 1'b0;

    // Any counting edge ends a terminal-count pulse, even after a one-shot went idle
    if (tin_fall) pulse_d = 1'b1;
    // Counting: one step of two per input pulse, twice per output cycle
    if (st_q == sqt_pkg::ST_RUN && tin_fall) begin
      if (cnt_q == `SQT_TERM_VALUE) begin
        if (!half_q) begin
          half_d = 1'b1;
          cnt_d  = half_load(len_q, 1'b1);
        end else begin
          term   = 1'b1;
          half_d = 1'b0;
          if (mode_q[1]) pulse_d = 1'b0;
          if (start_pend_q) begin
            mode_d       = new_mode;
            len_d        = new_len;
            cnt_d        = half_load(new_len, 1'b0);
            start_pend_d = 1'b0;
            halt_pend_d  = 1'b0;
          end else if (halt_pend_q || !mode_q[0]) begin
            st_d        = sqt_pkg::ST_IDLE;
            halt_pend_d = 1'b0;
          end else begin
            cnt_d = half_load(len_q, 1'b0);
          end
        end
      end else begin
        cnt_d = cnt_q - `SQT_CNT_W'(2);
      end
    end
    if (term) stat_d = 1'b1;

    // Timer commands; code 00 falls through untouched
    if (wr_cmd) begin
      unique case (cmd)
        sqt_pkg::CMD_NO_ACTION: ;
        sqt_pkg::CMD_STOP: begin
          st_d         = sqt_pkg::ST_IDLE;
          start_pend_d = 1'b0;
          halt_pend_d  = 1'b0;
          pulse_d      = 1'b1;
        end
        sqt_pkg::CMD_HALT_END: begin
          if (st_q == sqt_pkg::ST_RUN) halt_pend_d = 1'b1;
        end
        sqt_pkg::CMD_START: begin
          if (st_q == sqt_pkg::ST_RUN) begin
            start_pend_d = 1'b1;
          end else begin
            st_d    = sqt_pkg::ST_RUN;
            mode_d  = new_mode;
            len_d   = new_len;
            cnt_d   = half_load(new_len, 1'b0);
            half_d  = 1'b0;
            pulse_d = 1'b1;
          end
        end
      endcase
    end

    // Read data: status bit 6, or live counter with active mode bits.
    // The counter is always even, so bit 0 carries the first-half flag that lets
    // the host add the untouched second half to its remaining-count figure.
    unique case (addr_q)
      `SQT_ADDR_CMD:    rdat_d = {1'b0, stat_q, 6'h00};
      `SQT_ADDR_LEN_LO: rdat_d = {cnt_q[7:1], ~half_q};
      `SQT_ADDR_LEN_HI: rdat_d = {mode_q, cnt_q[`SQT_CNT_W-1:8]};
      default:          rdat_d = 8'h00;
    endcase
  end

  // Reset stops counting; mode, length and counter keep whatever they held
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q       <= 3'h0;
      sel_q        <= 1'b0;
      wdat_q       <= 8'h00;
      len_lo_q     <= `SQT_LEN_RESET;
      len_hi_q     <= `SQT_LEN_RESET;
      stat_q       <= 1'b0;
      st_q         <= sqt_pkg::ST_IDLE;
      start_pend_q <= 1'b0;
      halt_pend_q  <= 1'b0;
      pulse_q      <= 1'b1;
      half_q       <= 1'b0;
      rdat_q       <= 8'h00;
    end else begin
      addr_q       <= addr_d;
      sel_q        <= sel_d;
      wdat_q       <= wdat_d;
      len_lo_q     <= len_lo_d;
      len_hi_q     <= len_hi_d;
      stat_q       <= stat_d;
      st_q         <= st_d;
      start_pend_q <= start_pend_d;
      halt_pend_q  <= halt_pend_d;
      pulse_q      <= pulse_d;
      half_q       <= half_d;
      rdat_q       <= rdat_d;
    end
  end

  // Datapath registers without reset, so reset leaves mode and count unset
  always_ff @(posedge clk) begin
    mode_q <= mode_d;
    len_q  <= len_d;
    cnt_q  <= cnt_d;
  end

  // Output shaping: halves drive the wave modes, pulse flag the pulse modes
  logic out_d, out_q;
  always_comb begin
    if (st_q != sqt_pkg::ST_RUN) begin
      out_d = pulse_q;
    end else begin
      unique case (mode_q)
        sqt_pkg::WAVE_LOW_HALF,
        sqt_pkg::WAVE_SQUARE:    out_d = ~half_q;
        sqt_pkg::WAVE_ONE_PULSE,
        sqt_pkg::WAVE_PULSES:    out_d = pulse_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= 1'b1;
    end else begin
      out_q <= out_d;
    end
  end

  assign timer_out = out_q;
  assign ad_out    = rdat_q;
  // Drive only while a selected read is in progress
  assign ad_oe     = ~flt_q.rd_n & sel_q;

endmodule

// ---- sqt_consts.svh ----
// Address decode, field positions, terminal count value, widths and reset values of the interval timer
`ifndef SQT_CONSTS_SVH
`define SQT_CONSTS_SVH
`define SQT_ADDR_CMD      3'h0
`define SQT_ADDR_LEN_LO   3'h4
`define SQT_ADDR_LEN_HI   3'h5
`define SQT_CMD_POS       6
`define SQT_STAT_TIMER    6
`define SQT_MODE_POS      6
`define SQT_TERM_VALUE    14'h0002
`define SQT_LEN_RESET     8'h00
`define SQT_CNT_W         14
`define SQT_PINS_IDLE     14'h0700
`endif

// ---- sqt_pkg.sv ----
// Types shared by the interval timer: pin bundle, modes, commands and states
package sqt_pkg;
  typedef struct packed {
    logic       ale;
    logic       chip_sel;
    logic       io_sel;
    logic       rd_n;
    logic       wr_n;
    logic       timer_in;
    logic [7:0] ad;
  } sqt_pins_t;

  typedef enum logic [1:0] {
    WAVE_LOW_HALF = 2'h0,
    WAVE_SQUARE   = 2'h1,
    WAVE_ONE_PULSE = 2'h2,
    WAVE_PULSES   = 2'h3
  } sqt_mode_t;

  typedef enum logic [1:0] {
    CMD_NO_ACTION = 2'h0,
    CMD_STOP      = 2'h1,
    CMD_HALT_END  = 2'h2,
    CMD_START     = 2'h3
  } sqt_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1
  } sqt_state_t;
endpackage

// ---- sqt_timer_monitor.sv ----
// Port-level assertions for the interval timer
`timescale 1ns/10ps
module sqt_timer_monitor (
  input wire logic               clk,       // System clock
  input wire logic               rst,       // Synchronous reset
  input wire sqt_pkg::sqt_pins_t pins,      // Raw bus and timer pins
  input wire logic [7:0]         ad_out,    // Read data
  input wire logic               ad_oe,     // Bus drive enable
  input wire logic               timer_out  // Timer waveform
);
  logic [4:0] tin_q, tin_d, wr_q, wr_d, rd_q, rd_d;
  logic       ptin_q, pale_q, sel_q, sel_d;
  // Ages since timer-input fall, write strobe and read strobe; saturate so they never wrap
  always_comb begin
    tin_d = (ptin_q && !pins.timer_in) ? 5'h00 : tin_q + {4'h0, tin_q != 5'h1F};
    wr_d = !pins.wr_n ? 5'h00 : wr_q + {4'h0, wr_q != 5'h1F};
    rd_d = !pins.rd_n ? 5'h00 : rd_q + {4'h0, rd_q != 5'h1F};
    sel_d = (pale_q && !pins.ale) ? (pins.chip_sel && pins.io_sel) : sel_q;
  end
  always_ff @(posedge clk) begin
    ptin_q <= pins.timer_in;
    pale_q <= pins.ale;
    if (rst) begin
      {tin_q, wr_q, rd_q, sel_q} <= 16'h0000;
    end else begin
      {tin_q, wr_q, rd_q, sel_q} <= {tin_d, wr_d, rd_d, sel_d};
    end
  end
  a_reset_out_high: assert property (@(posedge clk) rst |=> timer_out)
    else $error("timer output not high after reset");
  a_reset_bus_quiet: assert property (@(posedge clk) rst |=> !ad_oe && ad_out == 8'h00)
    else $error("bus driven after reset");
  a_oe_needs_read: assert property (@(posedge clk) disable iff (rst)
    $rose(ad_oe) |-> !pins.rd_n) else $error("bus driven without a read");
  a_oe_needs_sel: assert property (@(posedge clk) disable iff (rst) ad_oe |-> sel_q)
    else $error("bus driven while not selected");
  a_oe_releases: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.rd_n) |-> ##[1:8] !ad_oe) else $error("bus not released");
  a_oe_idle_low: assert property (@(posedge clk) disable iff (rst)
    rd_q >= 5'h0A |-> !ad_oe) else $error("bus driven long after read");
  a_fall_has_cause: assert property (@(posedge clk) disable iff (rst)
    $fell(timer_out) |-> tin_q <= 5'h0E) else $error("output fell without input edge");
  a_out_quiet: assert property (@(posedge clk) disable iff (rst)
    tin_q >= 5'h10 && wr_q >= 5'h18 |-> $stable(timer_out)) else $error("output moved idle");
endmodule
bind sqt_timer sqt_timer_monitor mon_u (.clk(clk), .rst(rst), .pins(pins), .ad_out(ad_out),
  .ad_oe(ad_oe), .timer_out(timer_out));

// ---- sqt_host.sv ----
// Host processor bus model and timer-input source
`timescale 1ns/10ps
module sqt_host (
  input wire logic         clk,    // System clock
  input wire logic [7:0]   ad_out, // Read data from block
  input wire logic         ad_oe,  // Block drives bus
  output sqt_pkg::sqt_pins_t pins  // Bus and timer pins
);
  initial pins = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
  // One bus cycle; each level held well past the block's 3-stage input filter
  task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q, output logic oe);
    pins.ad <= {5'h00, a};
    pins.ale <= 1'b1;
    pins.chip_sel <= 1'b1;
    pins.io_sel <= 1'b1;
    repeat (6) @(posedge clk);
    pins.ale <= 1'b0;
    repeat (6) @(posedge clk);
    pins.ad <= w ? d : ~pins.ad; // Released bus shows no stale value
    if (w) pins.wr_n <= 1'b0;
    else pins.rd_n <= 1'b0;
    repeat (12) @(posedge clk);
    q = ad_out;
    oe = ad_oe;
    pins.wr_n <= 1'b1;
    pins.rd_n <= 1'b1;
    repeat (12) @(posedge clk);
    pins.chip_sel <= 1'b0;
    // Let an edge pass so a following call never re-drives chip_sel in this step
    @(posedge clk);
  endtask
  // One timer-input pulse; sampling at its end leaves room for the output delay
  task automatic pulse();
    pins.timer_in <= 1'b0;
    repeat (6) @(posedge clk);
    pins.timer_in <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- test_square_wave_interval_timer.sv ----
// Self-checking bench for the interval timer
`timescale 1ns/10ps
`include "sqt_consts.svh"
module test_square_wave_interval_timer;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  sqt_pkg::sqt_pins_t pins;
  logic [7:0]         ad_out, q;
  logic               ad_oe, timer_out;
  int                 n_fail = 0, cmp_count = 0, lows;
  always #4 clk = ~clk;
  sqt_timer dut_u (.clk(clk), .rst(rst), .pins(pins), .ad_out(ad_out), .ad_oe(ad_oe),
    .timer_out(timer_out));
  sqt_host host_u (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .pins(pins));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register access; the block drives the bus on reads only
  task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d);
    logic oe;
    host_u.bus(a, w, d, q, oe);
    chk({7'h00, oe}, {7'h00, !w});
  endtask
  task automatic cmd(input sqt_pkg::sqt_cmd_t c);
    acc(`SQT_ADDR_CMD, 1'b1, {c, 6'h00});
  endtask
  task automatic prog(input sqt_pkg::sqt_mode_t m, input logic [13:0] len);
    acc(`SQT_ADDR_LEN_LO, 1'b1, len[7:0]);
    acc(`SQT_ADDR_LEN_HI, 1'b1, {m, len[13:8]});
    cmd(sqt_pkg::CMD_START);
  endtask
  task automatic run(input int n);
    lows = 0;
    repeat (n) begin
      host_u.pulse();
      if (timer_out === 1'b0) lows++;
    end
  endtask
  task automatic t_reset();
    chk({6'h00, ad_oe, timer_out}, 8'h01);
    run(6);
    chk(8'(lows), 8'h00);
    $display("reset test done");
  endtask
  task automatic t_square();
    prog(sqt_pkg::WAVE_SQUARE, 14'h0005);
    for (int k = 1; k <= 10; k++) begin
      host_u.pulse();
      chk({7'h00, timer_out}, {7'h00, (k % 5) < 3});
    end
    acc(`SQT_ADDR_LEN_HI, 1'b0, 8'h00);
    chk({6'h00, q[7:6]}, 8'h01);
    acc(`SQT_ADDR_CMD, 1'b0, 8'h00);
    chk(q & 8'h40, 8'h40);
    acc(`SQT_ADDR_CMD, 1'b0, 8'h00);
    chk(q, 8'h00);
    acc(3'h3, 1'b0, 8'h00);
    chk(q, 8'h00);
    $display("square test done");
  endtask
  task automatic t_pending();
    acc(`SQT_ADDR_LEN_LO, 1'b1, 8'h04);
    acc(`SQT_ADDR_LEN_HI, 1'b1, 8'h40);
    run(10);
    chk(8'(lows), 8'h04);
    cmd(sqt_pkg::CMD_START);
    run(10);
    run(20);
    chk(8'(lows), 8'h0A);
    cmd(sqt_pkg::CMD_NO_ACTION);
    run(20);
    chk(8'(lows), 8'h0A);
    $display("pending test done");
  endtask
  task automatic t_stop();
    host_u.pulse(); // Into the low half so the stop has something to undo
    cmd(sqt_pkg::CMD_STOP);
    chk({7'h00, timer_out}, 8'h01);
    cmd(sqt_pkg::CMD_HALT_END);
    cmd(sqt_pkg::CMD_STOP);
    run(8);
    chk(8'(lows), 8'h00);
    prog(sqt_pkg::WAVE_SQUARE, 14'h0004);
    run(3);
    cmd(sqt_pkg::CMD_HALT_END);
    chk({7'h00, timer_out}, 8'h00);
    run(9);
    chk(8'(lows), 8'h00);
    $display("stop test done");
  endtask
  // Remaining count from a stopped read-back; an odd length still in its first half
  task automatic t_remain();
    logic [15:0] v;
    int          rem;
    prog(sqt_pkg::WAVE_SQUARE, 14'h0007);
    run(2);
    cmd(sqt_pkg::CMD_STOP);
    acc(`SQT_ADDR_LEN_LO, 1'b0, 8'h00);
    v[7:0] = q;
    acc(`SQT_ADDR_LEN_HI, 1'b0, 8'h00);
    v[15:8] = q & 8'h3F;
    rem = int'(v >> 1) + (v[0] ? (7 >> 1) : 0);
    chk(8'(rem), 8'h05);
    $display("remaining count test done");
  endtask
  // Reset in mid-count stops the timer; only a fresh start runs it again
  task automatic t_midreset();
    cmd(sqt_pkg::CMD_STOP);
    prog(sqt_pkg::WAVE_SQUARE, 14'h0004);
    run(2);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk({7'h00, timer_out}, 8'h01);
    run(8);
    chk(8'(lows), 8'h00);
    prog(sqt_pkg::WAVE_SQUARE, 14'h0004);
    run(4);
    chk(8'(lows), 8'h02);
    $display("mid-run reset test done");
  endtask
  task automatic t_modes();
    logic [7:0] exp [4] = '{8'h02, 8'h06, 8'h01, 8'h03};
    for (int i = 0; i < 4; i++) begin
      cmd(sqt_pkg::CMD_STOP);
      prog(sqt_pkg::sqt_mode_t'(2'(i)), 14'h0004);
      run(12);
      chk(8'(lows), exp[i]);
    end
    $display("mode test done");
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    t_square();
    t_pending();
    t_stop();
    t_remain();
    t_modes();
    t_midreset();
    stop_test();
  end
  // Whole run needs well under 10000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule
